// ===== core/srcs_pkg.sv
// constants and types for the reference capture and alignment block
package srcs_pkg;
  // register offsets
  localparam logic [11:0] SRCS_OFF_CLKDIV = 12'h10B;
  localparam logic [11:0] SRCS_OFF_CTRL = 12'h120;
  localparam logic [11:0] SRCS_OFF_IGNORE = 12'h121;
  localparam logic [11:0] SRCS_OFF_SKEW = 12'h122;
  localparam logic [11:0] SRCS_OFF_MON = 12'h128;
  localparam logic [11:0] SRCS_OFF_SYNC = 12'h1FF;
  // field positions
  localparam int SRCS_MODE_LSB = 1;
  localparam int SRCS_EDGE_BIT = 3;
  localparam int SRCS_TRANS_BIT = 4;
  localparam int SRCS_WNEG_LSB = 2;
  localparam int SRCS_WPOS_LSB = 0;
  // reset values
  localparam logic [7:0] SRCS_CLKDIV_RST = 8'h00;
  localparam logic [7:0] SRCS_CTRL_RST = 8'h00;
  localparam logic [7:0] SRCS_IGNORE_RST = 8'h00;
  localparam logic [7:0] SRCS_SKEW_RST = 8'h00;
  localparam logic [7:0] SRCS_SYNC_RST = 8'h00;
  localparam logic [7:0] SRCS_MON_RST = 8'h00;
  // mode encodings and limits
  localparam logic [1:0] SRCS_MODE_OFF = 2'h0;
  localparam logic [1:0] SRCS_MODE_CONT = 2'h1;
  localparam logic [1:0] SRCS_MODE_NSHOT = 2'h2;
  localparam logic [4:0] SRCS_IGNORE_MAX = 5'h10;
  localparam logic [3:0] SRCS_MON_CENTER = 4'h8;

  typedef struct packed {
    logic [1:0] mode;
    logic fall_edge;
    logic high_to_low;
    logic [4:0] ignore_n;
    logic [1:0] win_neg;
    logic [1:0] win_pos;
    logic [2:0] div_sel;
    logic [1:0] sync_mode;
  } srcs_cfg_t;

  typedef struct packed {
    logic [3:0] hold;
    logic [3:0] setup;
  } srcs_mon_t;

  typedef enum logic [1:0] {
    SRCS_IDLE,
    SRCS_COUNT,
    SRCS_RUN
  } srcs_state_t;
endpackage

// ===== core/srcs_capture.sv
// reference capture, lmfc alignment, skew window and margin monitor
//
// Notes on behaviour
// - mode field selects shot/continuous; writing 1 or 2 arms, 3 does not
// - n-shot mode field clears after acting
// - lmfc is sample clock over s times k
// - normal mode event resyncs dividers and link
// - transition bit picks rising or falling event
// - edge bit picks rising or falling sampling
// - n-shot ignores up to sixteen events first
// - continuous misaligned capture starts link resync
// - continuous captures inside skew window leave dividers alone
// - window negative bits 3:2, positive 1:0
// - negative before phase zero, positive after
// - monitor register: hold 7:4, setup 3:0
// - monitor encoding flags setup or hold error
// - total latency is dsp plus link latency
// - timestamp mode marks sample, no clock reset
`timescale 1ns/10ps
module srcs_capture
  import srcs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sysref_i,
  input wire logic [3:0] setup_det_i,
  input wire logic [3:0] hold_det_i,
  input wire logic [4:0] samples_per_frame_i,
  input wire logic [4:0] frames_per_mf_i,
  input wire logic [10:0] dsp_latency_i,
  input wire logic [8:0] link_latency_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic sample_strobe_o,
  output logic lmfc_o,
  output logic sync_pulse_o,
  output logic timestamp_o,
  output logic armed_o,
  output logic setup_err_o,
  output logic hold_err_o,
  output logic [11:0] total_latency_o
);

  // pin synchronisers; the falling-edge first stage lets the block sample
  // the reference on either clock edge
  logic sr_rise_m_q, sr_rise_s_q, sr_fall_m_q, sr_fall_s_q;
  logic [7:0] det_m_q, det_s_q;

  always_ff @(posedge clk_sys_i)
  begin
    sr_rise_m_q <= reset_n_i ? sysref_i : 1'b0;
    sr_rise_s_q <= reset_n_i ? sr_rise_m_q : 1'b0;
    sr_fall_s_q <= reset_n_i ? sr_fall_m_q : 1'b0;
    det_m_q <= reset_n_i ? {hold_det_i, setup_det_i} : 8'h00;
    det_s_q <= reset_n_i ? det_m_q : 8'h00;
  end

  always_ff @(negedge clk_sys_i)
  begin
    sr_fall_m_q <= reset_n_i ? sysref_i : 1'b0;
  end

  srcs_cfg_t cfg_q, cfg_d;
  srcs_state_t state_q, state_d;
  srcs_mon_t mon_q, mon_d;
  logic [4:0] ign_cnt_q, ign_cnt_d;
  logic [2:0] div_cnt_q, div_cnt_d;
  logic [9:0] lmfc_cnt_q, lmfc_cnt_d;
  logic lvl_prev_q, lvl_prev_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic strobe_q, strobe_d;
  logic lmfc_q, lmfc_d;
  logic sync_q, sync_d;
  logic ts_q, ts_d;
  logic serr_q, serr_d;
  logic herr_q, herr_d;
  logic [11:0] lat_q, lat_d;
  logic armed_q, armed_d;

  logic sel_lvl, ev, act, resync, in_win, ctrl_wr;
  logic [9:0] period, phase;
  logic [4:0] ign_lim;

  always_comb
  begin
    sel_lvl = cfg_q.fall_edge ? sr_fall_s_q : sr_rise_s_q;
    // the source keeps each pulse long enough that the synchronised level
    // never drops a transition between samples
    ev = cfg_q.high_to_low ? (lvl_prev_q & ~sel_lvl)
                           : (~lvl_prev_q & sel_lvl);
    period = 10'(samples_per_frame_i) * 10'(frames_per_mf_i);
    // phase this clock steps to: an event whole periods after a resync aligns
    phase = (div_cnt_q < cfg_q.div_sel) ? lmfc_cnt_q
      : (lmfc_cnt_q + 10'h001 >= period) ? 10'h000 : lmfc_cnt_q + 10'h001;
    // negative skew sits just before phase zero, positive just after
    in_win = (phase == 10'h000)
      || (phase <= {8'h00, cfg_q.win_pos})
      || ({8'h00, cfg_q.win_neg} >= 10'(period - phase));
    ign_lim = (cfg_q.ignore_n > SRCS_IGNORE_MAX) ? SRCS_IGNORE_MAX
                                                 : cfg_q.ignore_n;
    ctrl_wr = reg_wr_i && (reg_addr_i == SRCS_OFF_CTRL);
  end

  always_comb
  begin
    cfg_d = cfg_q;
    state_d = state_q;
    mon_d = mon_q;
    ign_cnt_d = ign_cnt_q;
    lvl_prev_d = sel_lvl;
    act = 1'b0;
    resync = 1'b0;
    ts_d = 1'b0;

    case (state_q)
      SRCS_IDLE: state_d = SRCS_IDLE;
      SRCS_COUNT:
      begin
        if (ev)
        begin
          if (ign_cnt_q < ign_lim)
          begin
            ign_cnt_d = ign_cnt_q + 5'h01;
          end
          else
          begin
            act = 1'b1;
            cfg_d.mode = SRCS_MODE_OFF;
            state_d = SRCS_IDLE;
            resync = ~cfg_q.sync_mode[0];
          end
        end
      end
      SRCS_RUN:
      begin
        if (ev)
        begin
          act = 1'b1;
          // a capture inside the window keeps dividers running
          resync = ~cfg_q.sync_mode[0] && ~in_win;
        end
      end
      default: state_d = SRCS_IDLE;
    endcase

    if (act)
    begin
      mon_d = det_s_q;
      ts_d = cfg_q.sync_mode[0];
    end

    // a software write to the mode field wins over the self clear so that
    // re-arming in the clearing cycle is not lost
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        SRCS_OFF_CLKDIV: cfg_d.div_sel = reg_wdata_i[2:0];
        SRCS_OFF_IGNORE: cfg_d.ignore_n = reg_wdata_i[4:0];
        SRCS_OFF_SKEW:
        begin
          cfg_d.win_neg = reg_wdata_i[SRCS_WNEG_LSB +: 2];
          cfg_d.win_pos = reg_wdata_i[SRCS_WPOS_LSB +: 2];
        end
        SRCS_OFF_SYNC: cfg_d.sync_mode = reg_wdata_i[1:0];
        SRCS_OFF_CTRL:
        begin
          cfg_d.mode = reg_wdata_i[SRCS_MODE_LSB +: 2];
          cfg_d.fall_edge = reg_wdata_i[SRCS_EDGE_BIT];
          cfg_d.high_to_low = reg_wdata_i[SRCS_TRANS_BIT];
          ign_cnt_d = 5'h00;
          case (reg_wdata_i[SRCS_MODE_LSB +: 2])
            SRCS_MODE_CONT: state_d = SRCS_RUN;
            SRCS_MODE_NSHOT: state_d = SRCS_COUNT;
            default: state_d = SRCS_IDLE;
          endcase
        end
        default:
        begin
          cfg_d = cfg_d;
        end
      endcase
    end
    armed_d = (state_d != SRCS_IDLE);
  end

  // sample clock divider and lmfc counter, both restarted by a resync
  always_comb
  begin
    strobe_d = 1'b0;
    lmfc_d = 1'b0;
    div_cnt_d = div_cnt_q;
    lmfc_cnt_d = lmfc_cnt_q;
    if (resync)
    begin
      div_cnt_d = 3'h0;
      lmfc_cnt_d = 10'h000;
    end
    else if (div_cnt_q >= cfg_q.div_sel)
    begin
      div_cnt_d = 3'h0;
      strobe_d = 1'b1;
      if (lmfc_cnt_q + 10'h001 >= period)
      begin
        lmfc_cnt_d = 10'h000;
        lmfc_d = 1'b1;
      end
      else
      begin
        lmfc_cnt_d = lmfc_cnt_q + 10'h001;
      end
    end
    else
    begin
      div_cnt_d = div_cnt_q + 3'h1;
    end
  end

  always_comb
  begin
    sync_d = resync;
    serr_d = (mon_q.hold == 4'h0) && (mon_q.setup < SRCS_MON_CENTER);
    herr_d = (mon_q.hold > SRCS_MON_CENTER) && (mon_q.setup == 4'h0);
    lat_d = {1'b0, dsp_latency_i} + {3'h0, link_latency_i};
    rvalid_d = reg_rd_i;
    rdata_d = rdata_q;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        SRCS_OFF_CLKDIV: rdata_d = {5'h00, cfg_q.div_sel};
        SRCS_OFF_CTRL: rdata_d = {3'h0, cfg_q.high_to_low,
                                  cfg_q.fall_edge, cfg_q.mode, 1'b0};
        SRCS_OFF_IGNORE: rdata_d = {3'h0, cfg_q.ignore_n};
        SRCS_OFF_SKEW: rdata_d = {4'h0, cfg_q.win_neg, cfg_q.win_pos};
        SRCS_OFF_MON: rdata_d = mon_q;
        SRCS_OFF_SYNC: rdata_d = {6'h00, cfg_q.sync_mode};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      cfg_q <= '0;
      state_q <= SRCS_IDLE;
      mon_q <= SRCS_MON_RST;
      ign_cnt_q <= 5'h00;
      div_cnt_q <= 3'h0;
      lmfc_cnt_q <= 10'h000;
      lvl_prev_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      strobe_q <= 1'b0;
      lmfc_q <= 1'b0;
      sync_q <= 1'b0;
      ts_q <= 1'b0;
      serr_q <= 1'b0;
      herr_q <= 1'b0;
      lat_q <= 12'h000;
      armed_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      state_q <= state_d;
      mon_q <= mon_d;
      ign_cnt_q <= ign_cnt_d;
      div_cnt_q <= div_cnt_d;
      lmfc_cnt_q <= lmfc_cnt_d;
      lvl_prev_q <= lvl_prev_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      strobe_q <= strobe_d;
      lmfc_q <= lmfc_d;
      sync_q <= sync_d;
      ts_q <= ts_d;
      serr_q <= serr_d;
      herr_q <= herr_d;
      lat_q <= lat_d;
      armed_q <= armed_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign sample_strobe_o = strobe_q;
  assign lmfc_o = lmfc_q;
  assign sync_pulse_o = sync_q;
  assign timestamp_o = ts_q;
  assign armed_o = armed_q;
  assign setup_err_o = serr_q;
  assign hold_err_o = herr_q;
  assign total_latency_o = lat_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  a_nshot_self_clear: assert property (
    (state_q == SRCS_COUNT && ev && ign_cnt_q >= ign_lim && !ctrl_wr)
    |=> (cfg_q.mode == SRCS_MODE_OFF) && (state_q == SRCS_IDLE))
    else $error("n-shot mode did not clear after acting");
  a_cont_arm: assert property (
    (ctrl_wr && reg_wdata_i[2:1] == SRCS_MODE_CONT) |=> state_q == SRCS_RUN)
    else $error("continuous mode write did not arm");
  a_ignore_clear: assert property (
    ctrl_wr |=> ign_cnt_q == 5'h00)
    else $error("ignore counter not cleared on arm");
  a_window_quiet: assert property (
    (state_q == SRCS_RUN && ev && in_win && !reg_wr_i) |=> !sync_pulse_o)
    else $error("resync issued for capture inside window");
  a_window_resync: assert property (
    (state_q == SRCS_RUN && ev && !in_win && !cfg_q.sync_mode[0])
    |=> sync_pulse_o && (lmfc_cnt_q == 10'h000))
    else $error("misaligned capture did not resync");
  a_timestamp_only: assert property (
    timestamp_o |-> !sync_pulse_o && $past(cfg_q.sync_mode[0]))
    else $error("timestamp mode reset the clocks");
  a_monitor_hold: assert property (
    !act |=> $stable(mon_q))
    else $error("monitor changed without a capture");
  a_lmfc_range: assert property (
    (period != 10'h000) |-> ##1 (lmfc_cnt_q < $past(period)
      || $past(lmfc_cnt_q) >= $past(period)))
    else $error("lmfc counter exceeded its period");
  a_setup_flag: assert property (
    (mon_q.hold == 4'h0 && mon_q.setup == 4'h3) |=> setup_err_o && !hold_err_o)
    else $error("setup error flag wrong");
endmodule

// ===== tb/srcs_ref_src.sv
// far-side reference source: pulses the reference pin on request
`timescale 1ns/10ps
module srcs_ref_src
(
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic idle_i,
  input wire logic [2:0] div_i,
  output logic sysref_o
);
  int cnt = 0;
  // pulse never shorter than the minimum, so any miss is the design's
  always @(negedge clk_sys_i)
  begin
    if (go_i)
      cnt = 2 * (div_i + 1);
    else if (cnt > 0)
      cnt = cnt - 1;
    sysref_o <= (cnt > 0) ? ~idle_i : idle_i;
  end
endmodule

// ===== tb/srcs_capture_tb_top.sv
// self-checking bench for the reference capture block
`timescale 1ns/10ps
module srcs_capture_tb_top;
  import srcs_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic [3:0] setup, hold;
  logic [4:0] spf, fpm;
  logic [10:0] dsp;
  logic [8:0] lnk;
  logic [11:0] addr, tot;
  logic [7:0] wdat, rdat, v, m;
  logic wr, rd, rv, lmfc, sync, ts, armed, serr, herr;
  logic go, idle, sref, fe, tr, strb;
  logic [2:0] div;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0;
  int s0;
  int n_strb = 0;
  int late[8] = '{0, 0, 4, 4, 5, 3, 4, 5};
  logic [7:0] rq[$];
  logic [1:0] eq[$];
  logic [4:0] ign[4] = '{5'h00, 5'h03, 5'h10, 5'h14};
  logic [11:0] offs[7] = '{SRCS_OFF_CLKDIV, SRCS_OFF_CTRL, SRCS_OFF_IGNORE,
    SRCS_OFF_SKEW, SRCS_OFF_MON, SRCS_OFF_SYNC, 12'h123};

  srcs_capture DUT (.clk_sys_i(clk), .reset_n_i(rst_n), .sysref_i(sref),
    .setup_det_i(setup), .hold_det_i(hold), .samples_per_frame_i(spf),
    .frames_per_mf_i(fpm), .dsp_latency_i(dsp), .link_latency_i(lnk),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .reg_rvalid_o(rv), .sample_strobe_o(strb),
    .lmfc_o(lmfc), .sync_pulse_o(sync), .timestamp_o(ts), .armed_o(armed),
    .setup_err_o(serr), .hold_err_o(herr), .total_latency_o(tot));
  srcs_ref_src SRC (.clk_sys_i(clk), .go_i(go), .idle_i(idle), .div_i(div),
    .sysref_o(sref));

  always #2 clk = ~clk;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(string w, logic [11:0] e, logic [11:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", w, e, g);
    end
  endtask

  task automatic wr_reg(logic [11:0] a, logic [7:0] d);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(negedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_reg(logic [11:0] a, logic [7:0] e);
    rq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(negedge clk);
    rd <= 1'b0;
    @(negedge clk);
  endtask

  task automatic fire();
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic wait_lmfc();
    @(negedge clk);
    for (int i = 0; i < 64 && lmfc !== 1'b1; i++)
      @(negedge clk);
  endtask

  task automatic wait_to(int t);
    while (cyc < t)
      @(negedge clk);
  endtask

  task automatic end_test(string n);
    check("pending events", 12'h000, 12'(eq.size()));
    $display("test %s done", n);
  endtask

  always @(negedge clk)
  begin
    if (rv === 1'b1)
      check("read data", rq.size() ? 12'(rq.pop_front()) : 12'hFFF, rdat);
    if ((sync | ts) === 1'b1)
      check("event", eq.size() ? 12'(eq.pop_front()) : 12'h000, {ts, sync});
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (strb === 1'b1)
      n_strb <= n_strb + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    {setup, hold, dsp, lnk, addr, wdat, wr, rd, go, idle, div} = '0;
    spf = 5'h01;
    fpm = 5'h08;
    void'($urandom(32'h1B6A));
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    foreach (offs[i])
      rd_reg(offs[i], 8'h00);
    v = 8'($urandom) & 8'h0F;
    wr_reg(SRCS_OFF_SKEW, v);
    rd_reg(SRCS_OFF_SKEW, v);
    wr_reg(SRCS_OFF_MON, 8'($urandom));
    rd_reg(SRCS_OFF_MON, 8'h00);
    wr_reg(12'h123, 8'hFF);
    rd_reg(12'h123, 8'h00);
    wr_reg(SRCS_OFF_CTRL, 8'hFE);
    check("armed", 1'b0, armed);
    rd_reg(SRCS_OFF_CTRL, 8'h1E);
    wr_reg(SRCS_OFF_CTRL, 8'h00);
    end_test("registers");
    dsp <= 11'($urandom);
    lnk <= 9'($urandom);
    spf <= 5'h02;
    fpm <= 5'h04;
    div <= 3'h1;
    wr_reg(SRCS_OFF_CLKDIV, 8'h01);
    check("latency", 12'(dsp) + 12'(lnk), tot);
    wait_lmfc();
    wait_lmfc();
    t0 = cyc;
    s0 = n_strb;
    wait_lmfc();
    check("lmfc period", 12'h010, 12'(cyc - t0));
    check("strobes", 12'h008, 12'(n_strb - s0));
    spf <= 5'h01;
    fpm <= 5'h08;
    div <= 3'h0;
    wr_reg(SRCS_OFF_CLKDIV, 8'h00);
    end_test("lmfc");
    for (int i = 0; i < 4; i++)
    begin
      {tr, fe} = 2'(i);
      idle <= tr;
      // a fixed setup code of 3 on the first shot exercises the flag check
      setup <= (i == 3) ? 4'h0 : (i == 0) ? 4'h3 : 4'($urandom_range(7));
      hold <= (i == 3) ? 4'($urandom_range(15, 9)) : 4'h0;
      wr_reg(SRCS_OFF_IGNORE, 8'(ign[i]));
      repeat (6) @(negedge clk);
      wr_reg(SRCS_OFF_CTRL, {3'h0, tr, fe, SRCS_MODE_NSHOT, 1'b0});
      check("armed", 1'b1, armed);
      repeat ((ign[i] > SRCS_IGNORE_MAX) ? SRCS_IGNORE_MAX : ign[i])
        fire();
      eq.push_back(2'h1);
      fire();
      check("armed", 1'b0, armed);
      rd_reg(SRCS_OFF_CTRL, {3'h0, tr, fe, 3'h0});
      m = {hold, setup};
      rd_reg(SRCS_OFF_MON, m);
      check("errors", {hold == 0 && setup < 8, hold > 8 && setup == 0},
        {serr, herr});
      end_test("shot");
    end
    // disarmed: a further edge must leave the margin reading alone
    setup <= ~setup;
    fire();
    rd_reg(SRCS_OFF_MON, m);
    idle <= 1'b0;
    wr_reg(SRCS_OFF_SYNC, 8'h01);
    wr_reg(SRCS_OFF_IGNORE, 8'h00);
    repeat (6) @(negedge clk);
    wr_reg(SRCS_OFF_CTRL, 8'h04);
    eq.push_back(2'h2);
    fire();
    wr_reg(SRCS_OFF_SYNC, 8'h00);
    end_test("timestamp");
    wr_reg(SRCS_OFF_SKEW, 8'h05);
    wr_reg(SRCS_OFF_CTRL, 8'h04);
    eq.push_back(2'h1);
    t0 = cyc;
    fire();
    wr_reg(SRCS_OFF_CTRL, 8'h02);
    // pulses 64 apart keep lmfc alignment; k=2 lands 4 late and resyncs,
    // k=4 and k=5 sit one inside the window, k=6 and k=7 run with no window
    for (int k = 1; k < 8; k++)
    begin
      if (k == 6)
        wr_reg(SRCS_OFF_SKEW, 8'h00);
      wait_to(t0 + 64 * k + late[k]);
      if (k == 2 || k == 7)
        eq.push_back(2'h1);
      fire();
    end
    wr_reg(SRCS_OFF_CTRL, 8'h00);
    end_test("continuous");
    close_out();
  end
endmodule
